// ===== rtl/ccc_regs.sv
// How it works
// (RULE_01) CRC on back channel follows enable bit.
// (RULE_02) Failsafe bit picks pull-up or pull-down.
// (RULE_03) Sync filter drops pulses under two clocks.
// (RULE_04) Pass-through forwards alias-matched I2C transactions.
// (RULE_05) Auto-ack acknowledges forwards regardless of lock.
// (RULE_06) Watchdog aborts transactions after programmed timeout.
// (RULE_07) Software never programs watchdog timeout zero.
// (RULE_08) Watchdog disable bit stops the watchdog.
// (RULE_09) Pass-all forwards every local I2C transaction.
// (RULE_10) SDA hold time in fifty nanosecond steps.
// (RULE_11) Glitch filter depth in five nanosecond steps.
// (RULE_12) Software keeps reserved fields at reset values.
// (RULE_13) Unmapped offsets are reserved and do nothing.
// (RULE_14) Alias address replaced by physical slave address.
// (RULE_15) Clock divided into watchdog tick and filter counts.
`include "ccc_map.svh"

module ccc_regs
    import ccc_pkg::*;
#(
    parameter int NUM_ALIAS   = `CCC_NUM_ALIAS,
    parameter int TICK_CYCLES = `CCC_WDOG_TICK_CYCLES
) (
    input  wire logic                       clock,
    input  wire logic                       arst_n,
    // Local register port of the serial control bus.
    input  wire logic [7:0]                 reg_addr,
    input  wire logic                       reg_wr_en,
    input  wire logic                       reg_rd_en,
    input  wire logic [7:0]                 reg_wdata,
    output logic      [7:0]                 reg_rdata,
    // Static controls.
    output logic                            bc_crc_en,
    output logic                            inputs_pull_down,
    output logic                            i2c_auto_ack,
    // Video sync inputs and their filtered copies.
    input  wire logic                       pixel_valid_in,
    input  wire logic                       line_sync_in,
    input  wire logic                       frame_sync_in,
    output logic                            pixel_valid_out,
    output logic                            line_sync_out,
    output logic                            frame_sync_out,
    // Local I2C pins after glitch filtering and SDA hold.
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    output logic                            scl_clean,
    output logic                            sda_clean,
    // Address phase of a local I2C transaction.
    input  wire logic                       i2c_addr_valid,
    input  wire logic [6:0]                 i2c_addr,
    input  wire logic                       fwd_locked,
    input  wire logic [NUM_ALIAS-1:0][6:0]  alias_id,
    input  wire logic [NUM_ALIAS-1:0][6:0]  slave_id,
    output logic                            fwd_req,
    output logic [6:0]                      fwd_addr,
    output logic                            fwd_ack,
    // Control channel transaction supervision.
    input  wire logic                       cc_txn_active,
    output logic                            cc_txn_abort,
    output logic                            wdog_running
);

    if (NUM_ALIAS < 1) begin : g_chk_alias
        $error("NUM_ALIAS must be at least one");
    end
    if (TICK_CYCLES < 2) begin : g_chk_tick
        $error("TICK_CYCLES must be at least two");
    end

    localparam int TW = $clog2(TICK_CYCLES);


    // Register bank.

    ccc_byte_t gcfg_q;
    ccc_byte_t wdctl_q;
    ccc_byte_t i2cctl_q;
    ccc_byte_t rdata_q;

    wire sel_gcfg   = reg_addr == `CCC_OFF_GENERAL_CONFIG_ONE;
    wire sel_wdctl  = reg_addr == `CCC_OFF_CHANNEL_WATCHDOG_CTRL;
    wire sel_i2cctl = reg_addr == `CCC_OFF_SERIAL_BUS_CONTROL_ONE;

    // Reserved bits are not writable, so a stray write cannot change them.
    wire ccc_byte_t gcfg_d = (gcfg_q & ~`CCC_WMASK_GENERAL_CONFIG_ONE)
                           | (reg_wdata & `CCC_WMASK_GENERAL_CONFIG_ONE); // (RULE_12)

    // Offsets outside the three registers read as zero and absorb writes.
    wire ccc_byte_t rd_mux = sel_gcfg   ? gcfg_q   :
                             sel_wdctl  ? wdctl_q  :
                             sel_i2cctl ? i2cctl_q : 8'h00; // (RULE_13)

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gcfg_q <= `CCC_RST_GENERAL_CONFIG_ONE;
        end else if (reg_wr_en && sel_gcfg) begin
            gcfg_q <= gcfg_d;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wdctl_q <= `CCC_RST_CHANNEL_WATCHDOG_CTRL;
        end else if (reg_wr_en && sel_wdctl) begin
            wdctl_q <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            i2cctl_q <= `CCC_RST_SERIAL_BUS_CONTROL_ONE;
        end else if (reg_wr_en && sel_i2cctl) begin
            i2cctl_q <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_en) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_rdata = rdata_q;


    // Field decode.

    wire       crc_en_f     = gcfg_q[`CCC_BIT_BC_CRC_EN];
    wire       pulldown_f   = gcfg_q[`CCC_BIT_FAILSAFE_PULLDOWN];
    wire       sync_filt_f  = gcfg_q[`CCC_BIT_SYNC_FILTER_EN];
    wire       pass_thru_f  = gcfg_q[`CCC_BIT_PASS_THROUGH];
    wire       auto_ack_f   = gcfg_q[`CCC_BIT_AUTO_ACK];
    wire [6:0] wd_timeout_f = wdctl_q[`CCC_FLD_WDOG_TIMEOUT_HI:`CCC_FLD_WDOG_TIMEOUT_LO];
    wire       wd_disable_f = wdctl_q[`CCC_BIT_WDOG_DISABLE];
    wire       pass_all_f   = i2cctl_q[`CCC_BIT_PASS_ALL];
    wire [2:0] sda_hold_f   = i2cctl_q[`CCC_FLD_SDA_HOLD_HI:`CCC_FLD_SDA_HOLD_LO];
    wire [3:0] glitch_f     = i2cctl_q[`CCC_FLD_GLITCH_DEPTH_HI:`CCC_FLD_GLITCH_DEPTH_LO];

    assign bc_crc_en        = crc_en_f;   // (RULE_01)
    assign inputs_pull_down = pulldown_f; // (RULE_02)
    assign i2c_auto_ack     = auto_ack_f; // (RULE_05)


    // Filter settings converted from nanoseconds to clock cycles.

    localparam logic [8:0] PERIOD_NS  = 9'(`CCC_CLK_PERIOD_NS);
    localparam logic [8:0] HOLD_STEP  = 9'(`CCC_SDA_HOLD_STEP_NS);
    localparam logic [8:0] GLIT_STEP  = 9'(`CCC_GLITCH_STEP_NS);
    localparam logic [2:0] SYNC_CYC   = 3'(`CCC_SYNC_FILTER_CYCLES);

    // Hold rounds up to whole cycles.
    wire [8:0] hold_ns    = 9'(sda_hold_f * HOLD_STEP);
    wire [8:0] hold_cyc9  = (hold_ns + PERIOD_NS - 9'h001) / PERIOD_NS; // (RULE_15)
    // A glitch of the programmed width rounds up, plus one sample.
    wire [8:0] glit_ns    = 9'(glitch_f * GLIT_STEP);
    wire [8:0] glit_cyc9  = (glit_ns + PERIOD_NS - 9'h001) / PERIOD_NS; // (RULE_15)

    ccc_filt_if filt_bus ();

    assign filt_bus.raw         = {sda_in, scl_in, frame_sync_in, line_sync_in, pixel_valid_in};
    assign filt_bus.sync_thr    = sync_filt_f ? SYNC_CYC : 3'h1;          // (RULE_03)
    assign filt_bus.glitch_thr  = 3'(glit_cyc9) + 3'h1;                   // (RULE_11)
    assign filt_bus.hold_cycles = hold_cyc9[3:0];                         // (RULE_10)

    ccc_filter u_filter (
        .clock  (clock),
        .arst_n (arst_n),
        .f      (filt_bus.filt)
    );

    assign pixel_valid_out = filt_bus.clean[0];
    assign line_sync_out   = filt_bus.clean[1];
    assign frame_sync_out  = filt_bus.clean[2];
    assign scl_clean       = filt_bus.clean[3];
    assign sda_clean       = filt_bus.clean[4];


    // Pass-through decision and address remap.

    logic [NUM_ALIAS-1:0] alias_hit;

    for (genvar i = 0; i < NUM_ALIAS; i++) begin : g_alias
        assign alias_hit[i] = alias_id[i] == i2c_addr;
    end

    // The lowest matching entry wins.
    ccc_i2c_addr_t remap_addr;
    always_comb begin
        remap_addr = i2c_addr;
        for (int i = NUM_ALIAS - 1; i >= 0; i--) begin
            if (alias_hit[i]) begin
                remap_addr = slave_id[i]; // (RULE_14)
            end
        end
    end

    wire any_hit  = |alias_hit;
    wire do_fwd   = i2c_addr_valid && ((pass_thru_f && any_hit) || pass_all_f); // (RULE_04) (RULE_09)
    wire ack_ok   = fwd_locked || auto_ack_f; // (RULE_05)

    logic          fwd_req_q;
    logic          fwd_ack_q;
    ccc_i2c_addr_t fwd_addr_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fwd_req_q  <= 1'b0;
            fwd_ack_q  <= 1'b0;
            fwd_addr_q <= 7'h00;
        end else begin
            fwd_req_q  <= do_fwd;
            fwd_ack_q  <= do_fwd && ack_ok;
            fwd_addr_q <= do_fwd ? remap_addr : fwd_addr_q;
        end
    end

    assign fwd_req  = fwd_req_q;
    assign fwd_ack  = fwd_ack_q;
    assign fwd_addr = fwd_addr_q;


    // Control channel watchdog.

    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    ccc_wd_state_t wd_state_q;
    ccc_wd_state_t wd_state_d;
    logic [TW-1:0] presc_q;
    logic [6:0]    ticks_q;
    logic          abort_q;

    // The prescaler restarts with each transaction, so no step is cut short.
    wire tick     = (wd_state_q == CCC_WD_RUN) && (presc_q == TICK_LAST); // (RULE_15)
    wire expire   = tick && ((ticks_q + 7'h01) >= wd_timeout_f);          // (RULE_06)

    always_comb begin
        wd_state_d = wd_state_q;
        unique case (wd_state_q)
            CCC_WD_IDLE: begin
                if (cc_txn_active && !wd_disable_f) begin
                    wd_state_d = CCC_WD_RUN;
                end
            end
            CCC_WD_RUN: begin
                if (wd_disable_f || !cc_txn_active) begin
                    wd_state_d = CCC_WD_IDLE; // (RULE_08)
                end else if (expire) begin
                    wd_state_d = CCC_WD_EXPIRED;
                end
            end
            CCC_WD_EXPIRED: begin
                if (!cc_txn_active) begin
                    wd_state_d = CCC_WD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wd_state_q <= CCC_WD_IDLE;
            presc_q    <= '0;
            ticks_q    <= 7'h00;
            abort_q    <= 1'b0;
        end else begin
            wd_state_q <= wd_state_d;
            presc_q    <= (wd_state_q != CCC_WD_RUN || tick) ? '0 : presc_q + TW'(1);
            ticks_q    <= (wd_state_d != CCC_WD_RUN) ? 7'h00 : ticks_q + 7'(tick);
            abort_q    <= (wd_state_q == CCC_WD_RUN) && (wd_state_d == CCC_WD_EXPIRED); // (RULE_06)
        end
    end

    assign cc_txn_abort = abort_q;
    assign wdog_running = wd_state_q == CCC_WD_RUN;

endmodule : ccc_regs

// ===== include/ccc_map.svh
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH

// Register offsets.
`define CCC_OFF_GENERAL_CONFIG_ONE      8'h03
`define CCC_OFF_CHANNEL_WATCHDOG_CTRL   8'h04
`define CCC_OFF_SERIAL_BUS_CONTROL_ONE  8'h05

// Reset values.
`define CCC_RST_GENERAL_CONFIG_ONE      8'hF0
`define CCC_RST_CHANNEL_WATCHDOG_CTRL   8'hFE
`define CCC_RST_SERIAL_BUS_CONTROL_ONE  8'h1E

// Writable bits of general_config_one.
`define CCC_WMASK_GENERAL_CONFIG_ONE    8'h7C

// Field positions in general_config_one.
`define CCC_BIT_BC_CRC_EN               6
`define CCC_BIT_FAILSAFE_PULLDOWN       5
`define CCC_BIT_SYNC_FILTER_EN          4
`define CCC_BIT_PASS_THROUGH            3
`define CCC_BIT_AUTO_ACK                2

// Field positions in channel_watchdog_control.
`define CCC_FLD_WDOG_TIMEOUT_HI         7
`define CCC_FLD_WDOG_TIMEOUT_LO         1
`define CCC_BIT_WDOG_DISABLE            0

// Field positions in serial_bus_control_one.
`define CCC_BIT_PASS_ALL                7
`define CCC_FLD_SDA_HOLD_HI             6
`define CCC_FLD_SDA_HOLD_LO             4
`define CCC_FLD_GLITCH_DEPTH_HI         3
`define CCC_FLD_GLITCH_DEPTH_LO         0

// Timing in clock rate and step units.
`define CCC_CLK_KHZ                     40000
`define CCC_CLK_PERIOD_NS               25
`define CCC_WDOG_STEP_MS                2
`define CCC_SDA_HOLD_STEP_NS            50
`define CCC_GLITCH_STEP_NS              5
`define CCC_WDOG_TICK_CYCLES            (`CCC_WDOG_STEP_MS * `CCC_CLK_KHZ)

// Shortest sync pulse passed, in clock periods.
`define CCC_SYNC_FILTER_CYCLES          2
`define CCC_NUM_ALIAS                   8

`endif

// ===== include/ccc_pkg.sv
package ccc_pkg;

    typedef enum logic [1:0] {
        CCC_WD_IDLE,
        CCC_WD_RUN,
        CCC_WD_EXPIRED
    } ccc_wd_state_t;

    typedef logic [7:0] ccc_byte_t;
    typedef logic [6:0] ccc_i2c_addr_t;

endpackage : ccc_pkg

// ===== include/ccc_filt_if.sv
interface ccc_filt_if;
    // Channel order: 0 pixel_valid, 1 line_sync, 2 frame_sync, 3 scl, 4 sda.
    logic [4:0] raw;
    logic [4:0] clean;
    logic [2:0] sync_thr;
    logic [2:0] glitch_thr;
    logic [3:0] hold_cycles;

    modport ctrl (
        output raw,
        output sync_thr,
        output glitch_thr,
        output hold_cycles,
        input  clean
    );

    modport filt (
        input  raw,
        input  sync_thr,
        input  glitch_thr,
        input  hold_cycles,
        output clean
    );
endinterface : ccc_filt_if

// ===== rtl/ccc_filter.sv
module ccc_filter
    import ccc_pkg::*;
(
    input  wire logic clock,
    input  wire logic arst_n,
    ccc_filt_if.filt  f
);
    localparam int NCH  = 5;
    localparam int HMAX = 16;

    logic [NCH-1:0]  out_q;
    logic [HMAX-1:0] sda_pipe_q;
    logic            sda_held_q;
    wire  [3:0]      hold_tap = f.hold_cycles - 4'h1;

    // A channel follows its input only after thr differing samples in a row.
    for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
        logic [2:0] cnt_q;
        wire  [2:0] thr  = (ch < 3) ? f.sync_thr : f.glitch_thr;
        wire        diff = f.raw[ch] != out_q[ch];
        wire        take = diff && ((cnt_q + 3'h1) >= thr);
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                cnt_q      <= 3'h0;
                out_q[ch]  <= (ch >= 3) ? 1'b1 : 1'b0;
            end else begin
                cnt_q      <= (diff && !take) ? cnt_q + 3'h1 : 3'h0;
                out_q[ch]  <= take ? f.raw[ch] : out_q[ch];
            end
        end
    end

    // SDA lags by the hold so that it changes after SCL.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sda_pipe_q <= {HMAX{1'b1}};
            sda_held_q <= 1'b1;
        end else begin
            sda_pipe_q <= {sda_pipe_q[HMAX-2:0], out_q[4]};
            sda_held_q <= (f.hold_cycles == 4'h0) ? out_q[4] : sda_pipe_q[hold_tap]; // (RULE_10)
        end
    end

    assign f.clean = {sda_held_q, out_q[3:0]};

endmodule : ccc_filter

// ===== dv/ccc_far_model.sv
module ccc_far_model (
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic fwd_req,
    input  wire logic cc_txn_abort,
    input  wire logic stall,
    output logic      cc_txn_active
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] left_q;

    // A stalled far end never finishes, so only the watchdog can close its transaction.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cc_txn_active <= 1'b0;
            left_q        <= 2'h0;
        end else if (cc_txn_abort) begin
            cc_txn_active <= 1'b0;
        end else if (fwd_req && !cc_txn_active) begin
            cc_txn_active <= 1'b1;
            left_q        <= 2'h3;
        end else if (left_q != 2'h0) begin
            left_q <= left_q - 2'h1;
        end else if (!stall) begin
            cc_txn_active <= 1'b0;
        end
    end
endmodule : ccc_far_model

// ===== dv/ccc_regs_properties.sv
`include "ccc_map.svh"

module ccc_regs_properties
    import ccc_pkg::*;
#(
    parameter int NUM_ALIAS   = 8,
    parameter int TICK_CYCLES = 4
) (
    input wire logic                      clock,
    input wire logic                      arst_n,
    input wire logic [7:0]                reg_addr,
    input wire logic                      reg_wr_en,
    input wire logic                      reg_rd_en,
    input wire logic [7:0]                reg_wdata,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      bc_crc_en,
    input wire logic                      inputs_pull_down,
    input wire logic                      i2c_auto_ack,
    input wire logic                      pixel_valid_in,
    input wire logic                      pixel_valid_out,
    input wire logic                      i2c_addr_valid,
    input wire logic [6:0]                i2c_addr,
    input wire logic                      fwd_locked,
    input wire logic [NUM_ALIAS-1:0][6:0] alias_id,
    input wire logic [NUM_ALIAS-1:0][6:0] slave_id,
    input wire logic                      fwd_req,
    input wire logic [6:0]                fwd_addr,
    input wire logic                      fwd_ack,
    input wire logic                      cc_txn_abort,
    input wire logic                      wdog_running
);
    ccc_byte_t     sh03_q, sh04_q, sh05_q, rd_exp;
    ccc_i2c_addr_t remap;
    logic          hit;
    int unsigned   run_q;
    int unsigned   lim;

    // Shadow copies of the registers.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sh03_q <= `CCC_RST_GENERAL_CONFIG_ONE;
            sh04_q <= `CCC_RST_CHANNEL_WATCHDOG_CTRL;
            sh05_q <= `CCC_RST_SERIAL_BUS_CONTROL_ONE;
            run_q  <= 0;
        end else begin
            run_q <= wdog_running ? run_q + 1 : 0;
            if (reg_wr_en && reg_addr == `CCC_OFF_GENERAL_CONFIG_ONE)
                sh03_q <= (reg_wdata & 8'h7C) | 8'h80;
            if (reg_wr_en && reg_addr == `CCC_OFF_CHANNEL_WATCHDOG_CTRL)
                sh04_q <= reg_wdata;
            if (reg_wr_en && reg_addr == `CCC_OFF_SERIAL_BUS_CONTROL_ONE)
                sh05_q <= reg_wdata;
        end
    end

    always_comb begin
        hit   = 1'b0;
        remap = i2c_addr;
        for (int i = NUM_ALIAS - 1; i >= 0; i--) begin
            if (alias_id[i] == i2c_addr) begin
                hit   = 1'b1;
                remap = slave_id[i];
            end
        end
    end

    assign rd_exp = (reg_addr == 8'h03) ? sh03_q : (reg_addr == 8'h04) ? sh04_q :
                    (reg_addr == 8'h05) ? sh05_q : 8'h00;
    assign lim = ((sh04_q[7:1] == 7'h00) ? 1 : 32'(sh04_q[7:1])) * TICK_CYCLES;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_alias_hit;
        i2c_addr_valid && sh03_q[3] && hit;
    endsequence
    sequence s_pass_all;
        i2c_addr_valid && sh05_q[7];
    endsequence
    sequence s_glitch;
        sh03_q[4] && !pixel_valid_out && !$past(pixel_valid_in) && pixel_valid_in
            ##1 !pixel_valid_in;
    endsequence

    crc_follows_a: assert property (bc_crc_en == sh03_q[6])
        else $error("crc enable wrong");
    pull_follows_a: assert property (inputs_pull_down == sh03_q[5])
        else $error("pull wrong");
    autoack_follows_a: assert property (i2c_auto_ack == sh03_q[2])
        else $error("auto ack wrong");
    read_map_a: assert property (reg_rd_en |=> reg_rdata == $past(rd_exp))
        else $error("read data wrong");
    alias_fwd_a: assert property (s_alias_hit |=> fwd_req && fwd_addr == $past(remap))
        else $error("alias forward wrong");
    pass_all_a: assert property (s_pass_all |=> fwd_req)
        else $error("pass all missed");
    no_fwd_a: assert property (!(i2c_addr_valid && (sh05_q[7] || (sh03_q[3] && hit)))
        |=> !fwd_req)
        else $error("stray forward");
    fwd_ack_a: assert property ((fwd_req || fwd_ack)
        |-> fwd_req && fwd_ack == ($past(fwd_locked) || $past(i2c_auto_ack)))
        else $error("ack wrong");
    sync_glitch_a: assert property (s_glitch |-> !pixel_valid_out [*3])
        else $error("sync glitch passed");
    abort_time_a: assert property (cc_txn_abort |-> run_q == lim)
        else $error("abort mistimed");
    run_bound_a: assert property (wdog_running |-> run_q < lim)
        else $error("watchdog overran");
    wdog_off_a: assert property (sh04_q[0] |=> !wdog_running && !cc_txn_abort)
        else $error("watchdog not stopped");
endmodule : ccc_regs_properties

bind ccc_regs ccc_regs_properties #(.NUM_ALIAS(NUM_ALIAS), .TICK_CYCLES(TICK_CYCLES)) u_props (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bc_crc_en(bc_crc_en), .inputs_pull_down(inputs_pull_down), .i2c_auto_ack(i2c_auto_ack),
    .pixel_valid_in(pixel_valid_in), .pixel_valid_out(pixel_valid_out),
    .i2c_addr_valid(i2c_addr_valid), .i2c_addr(i2c_addr), .fwd_locked(fwd_locked),
    .alias_id(alias_id), .slave_id(slave_id), .fwd_req(fwd_req), .fwd_addr(fwd_addr),
    .fwd_ack(fwd_ack), .cc_txn_abort(cc_txn_abort), .wdog_running(wdog_running));

// ===== dv/control_channel_config_regs_bench.sv
`define CCC_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module control_channel_config_regs_bench;
    import ccc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int TICK = 4;
    localparam logic [4:0] IDLE = 5'h18;

    logic clock = 1'b0, arst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0, stall = 1'b0;
    logic pixel_valid_in = 1'b0, line_sync_in = 1'b0, frame_sync_in = 1'b0;
    logic scl_in = 1'b1, sda_in = 1'b1, i2c_addr_valid = 1'b0, fwd_locked = 1'b0;
    logic bc_crc_en, inputs_pull_down, i2c_auto_ack, pixel_valid_out, line_sync_out;
    logic frame_sync_out, scl_clean, sda_clean, fwd_req, fwd_ack, cc_txn_active;
    logic cc_txn_abort, wdog_running;
    ccc_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv, wv;
    ccc_i2c_addr_t i2c_addr = 7'h00, fwd_addr;
    logic [7:0][6:0] alias_id, slave_id;
    logic [4:0] seen;
    logic [9:0] ex;
    int n_fail = 0, n_checks = 0, seed = 32'h13EF0AA3, k, n0, n3;
    wire logic [4:0] clean_v = {sda_clean, scl_clean, frame_sync_out, line_sync_out,
                                pixel_valid_out};

    always #12.5 clock = ~clock;

    ccc_regs #(.NUM_ALIAS(8), .TICK_CYCLES(TICK)) u_ccc_regs (
        .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .bc_crc_en(bc_crc_en), .inputs_pull_down(inputs_pull_down),
        .i2c_auto_ack(i2c_auto_ack), .pixel_valid_in(pixel_valid_in),
        .line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in),
        .pixel_valid_out(pixel_valid_out), .line_sync_out(line_sync_out),
        .frame_sync_out(frame_sync_out), .scl_in(scl_in), .sda_in(sda_in),
        .scl_clean(scl_clean), .sda_clean(sda_clean), .i2c_addr_valid(i2c_addr_valid),
        .i2c_addr(i2c_addr), .fwd_locked(fwd_locked), .alias_id(alias_id),
        .slave_id(slave_id), .fwd_req(fwd_req), .fwd_addr(fwd_addr), .fwd_ack(fwd_ack),
        .cc_txn_active(cc_txn_active), .cc_txn_abort(cc_txn_abort),
        .wdog_running(wdog_running));

    ccc_far_model u_ccc_far_model (.clock(clock), .arst_n(arst_n), .fwd_req(fwd_req),
        .cc_txn_abort(cc_txn_abort), .stall(stall), .cc_txn_active(cc_txn_active));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic wr(input ccc_byte_t a, input ccc_byte_t d);
        @(negedge clock);
        {reg_addr, reg_wdata, reg_wr_en} = {a, d, 1'b1};
        @(negedge clock);
        reg_wr_en = 1'b0;
    endtask : wr

    task automatic rd(input ccc_byte_t a, output ccc_byte_t d);
        @(negedge clock);
        {reg_addr, reg_rd_en} = {a, 1'b1};
        @(negedge clock);
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask : rd

    task automatic fwd(input ccc_i2c_addr_t a);
        @(negedge clock);
        {i2c_addr, i2c_addr_valid} = {a, 1'b1};
        @(negedge clock);
        i2c_addr_valid = 1'b0;
    endtask : fwd

    // Pulses masked channels for len cycles; s marks outputs that moved.
    task automatic pulse(input int len, input logic [4:0] m, output logic [4:0] s);
        s = 5'h00;
        for (int i = 0; i < len + 16; i++) begin
            @(negedge clock);
            {sda_in, scl_in, frame_sync_in, line_sync_in, pixel_valid_in} = (i < len) ?
                IDLE ^ m : IDLE;
            s |= clean_v ^ IDLE;
        end
    endtask : pulse

    task automatic sda_lag(output int n);
        @(negedge clock);
        sda_in = 1'b0;
        for (n = 0; n < 60 && sda_clean !== 1'b0; n++)
            @(negedge clock);
        sda_in = 1'b1;
        repeat (30) @(negedge clock);
    endtask : sda_lag

    // Lowest matching alias wins; bit 9 says the address is checkable.
    function automatic logic [9:0] exp_fwd(input ccc_i2c_addr_t a, input logic pt, pa, ak);
        logic h;
        ccc_i2c_addr_t ad;
        h = 1'b0;
        ad = a;
        for (int i = 7; i >= 0; i--)
            if (alias_id[i] == a) {h, ad} = {1'b1, slave_id[i]};
        if (!(pa || (pt && h)))
            return 10'h000;
        return {pt || !h, 1'b1, ak, ad};
    endfunction : exp_fwd

    initial begin
        #(25 * 20000);
        n_fail++;
        conclude();
    end

    initial begin
        ccc_byte_t offs [7] = '{8'h03, 8'h04, 8'h05, 8'h00, 8'h02, 8'h06, 8'hFF};
        ccc_byte_t rsts [7] = '{8'hF0, 8'hFE, 8'h1E, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            alias_id[i] = 7'h10 + 7'(3 * i);
            slave_id[i] = 7'($random(seed));
        end
        alias_id[5] = alias_id[2];
        repeat (8) @(negedge clock);
        arst_n = 1'b1;
        `CCC_CHK({bc_crc_en, inputs_pull_down, i2c_auto_ack, wdog_running}, 4'hC)
        for (int i = 0; i < 7; i++) begin
            rd(offs[i], rv);
            `CCC_CHK(rv, rsts[i])
        end
        $display("test reset values done");
        for (int i = 0; i < 12; i++) begin
            k = 3 + (($random(seed) & 32'h7FFF) % 3);
            wv = 8'($random(seed));
            if (k == 3) wv = (wv & 8'h7C) | 8'h80;
            if (k == 4 && wv[7:1] == 7'h00) wv[1] = 1'b1;
            wr(8'(k), wv);
            wr(8'h06, ~wv);
            rd(8'(k), rv);
            `CCC_CHK(rv, wv)
        end
        wr(8'h03, 8'h0F);
        rd(8'h03, rv);
        `CCC_CHK(rv, 8'h8C)
        wr(8'h03, 8'hF0);
        wr(8'h04, 8'h04);
        wr(8'h05, 8'h1E);
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            k = $random(seed);
            fwd_locked = k[3];
            wr(8'h03, 8'hF0 | {4'h0, k[0], k[2], 2'h0});
            wr(8'h05, {k[1], 7'h1E});
            i2c_addr = k[4] ? alias_id[k[7:5]] : 7'(k >> 8);
            ex = exp_fwd(i2c_addr, k[0], k[1], k[3] | k[2]);
            fwd(i2c_addr);
            `CCC_CHK({fwd_req, fwd_ack}, ex[8:7])
            if (ex[9] && ex[8]) `CCC_CHK(fwd_addr, ex[6:0])
        end
        wr(8'h03, 8'hF8);
        $display("test forwarding done");
        for (int c = 0; c < 2; c++) begin
            wr(8'h04, 8'h04 | 8'(c));
            stall = c[0];
            seen = 5'h00;
            fwd(alias_id[0]);
            repeat (20) @(negedge clock) seen |= {3'h0, cc_txn_abort, wdog_running};
            `CCC_CHK(seen[1:0], {1'b0, ~c[0]})
            stall = 1'b0;
            repeat (8) @(negedge clock);
        end
        wr(8'h04, 8'h04);
        stall = 1'b1;
        fwd(alias_id[0]);
        for (k = 0; k < 400 && cc_txn_abort !== 1'b1; k++)
            @(negedge clock);
        `CCC_CHK(k, 2 * TICK + 2)
        @(negedge clock);
        `CCC_CHK(cc_txn_abort, 1'b0)
        stall = 1'b0;
        wr(8'h05, 8'h1E);
        $display("test watchdog done");
        pulse(1, 5'h07, seen);
        `CCC_CHK(seen[2:0], 3'h0)
        pulse(2, 5'h07, seen);
        `CCC_CHK(seen[2:0], 3'h7)
        wr(8'h03, 8'hE0);
        pulse(1, 5'h07, seen);
        `CCC_CHK(seen[2:0], 3'h7)
        wr(8'h03, 8'hF0);
        wr(8'h05, 8'h05);
        pulse(2, 5'h18, seen);
        `CCC_CHK(seen[4:3], 2'h3)
        wr(8'h05, 8'h06);
        pulse(2, 5'h18, seen);
        `CCC_CHK(seen[4:3], 2'h0)
        wr(8'h05, 8'h00);
        sda_lag(n0);
        wr(8'h05, 8'h30);
        sda_lag(n3);
        `CCC_CHK(n3 - n0, 6)
        $display("test filters done");
        conclude();
    end
endmodule : control_channel_config_regs_bench
